// ==== rtl/gpq_pin_filter.sv ====
// Qualification filter for one synchronized pin.
// Assumes level_in is already two flip-flops past the pin.

`timescale 1ns/10ps
`default_nettype none

module gpq_pin_filter
  import gpq_pkg::*;
(
  // Clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // Sampling
  input  wire logic      level_in,
  input  wire logic      tick,
  input  wire gpq_mode_t mode,
  // Result
  output logic           level_out
);

  logic [GPQ_HIST_W-1:0] hist_q;
  logic                  all3_hi;
  logic                  all3_lo;
  logic                  all6_hi;
  logic                  all6_lo;

  // ==========================================================
  // Sample history, kept in every mode for clean switching
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_q <= '0;
    end else if (tick) begin
      hist_q <= {hist_q[GPQ_HIST_W-2:0], level_in};
    end
  end

  // Current sample plus older ones: 3 samples span 2 periods, 6 span 5
  assign all3_hi = level_in & (&hist_q[1:0]);
  assign all3_lo = ~(level_in | (|hist_q[1:0]));
  assign all6_hi = level_in & (&hist_q);
  assign all6_lo = ~(level_in | (|hist_q));

  // ==========================================================
  // Qualified level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_out <= 1'b0;
    end else begin
      unique case (mode)
        GPQ_S3: begin
          // Short glitches never make all samples agree
          if (tick && (all3_hi || all3_lo)) begin
            level_out <= level_in;
          end
        end
        GPQ_S6: begin
          if (tick && (all6_hi || all6_lo)) begin
            level_out <= level_in;
          end
        end
        // Async peripheral mode still feeds the level register here
        GPQ_SYNC, GPQ_ASYNC: begin
          level_out <= level_in;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== rtl/gpq_pkg.sv ====
// Constants, register map and mode codes for the GPIO input qualifier.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
//
// Behaviour
// - Peripheral inputs may bypass all clocking and see the raw pin level.
// - Unsynchronized mode on a GPIO input falls back to synchronize-only.
// - After reset every pin is in synchronize-only mode with no filtering.
// - Synchronize-only registers the pin on the system clock, no filtering.
// - Sampling-window mode synchronizes first, then changes after matching samples.
// - One period field serves each group of eight consecutive pins.
// - Period zero samples every cycle; value n samples every 2n cycles.
// - Per-pin select chooses three or six samples in window mode.
// - Qualified level changes only when all selected samples agree, else holds.
// - Window spans one period fewer than samples: two or five periods.
// - Select code 1,0 picks six-sample window qualification.
// - Pulses shorter than the window are rejected; level is kept.
// - Qualifier and function configuration writes act two cycles later.
// - Port level register returns each pin's qualified level, any function.

package gpq_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] GPQ_PERIOD_OFS  = 8'h00;
  localparam logic [7:0] GPQ_QSEL_LO_OFS = 8'h04;
  localparam logic [7:0] GPQ_QSEL_HI_OFS = 8'h08;
  localparam logic [7:0] GPQ_FUNC_OFS    = 8'h0c;
  localparam logic [7:0] GPQ_LEVEL_OFS   = 8'h10;

  // ==========================================================
  // Field layout and reset values
  localparam int          GPQ_GROUP_PINS = 8;
  localparam int          GPQ_PERIOD_W   = 8;
  localparam int          GPQ_QSEL_W     = 2;
  localparam int          GPQ_QSEL_PINS  = 16;
  localparam logic [31:0] GPQ_PERIOD_RST = 32'h0000_0000;
  localparam logic [31:0] GPQ_QSEL_RST   = 32'h0000_0000;
  localparam logic [31:0] GPQ_FUNC_RST   = 32'h0000_0000;

  // ==========================================================
  // Timing
  localparam int GPQ_SYNC_STAGES = 2;
  localparam int GPQ_HIST_W      = 5;
  localparam int GPQ_CNT_W       = GPQ_PERIOD_W + 1;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] GPQ_RESP_OKAY   = 2'b00;
  localparam logic [1:0] GPQ_RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    GPQ_SYNC  = 2'b00,
    GPQ_S3    = 2'b01,
    GPQ_S6    = 2'b10,
    GPQ_ASYNC = 2'b11
  } gpq_mode_t;

  function automatic logic [31:0] gpq_strb(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ==== rtl/gpq_qualifier.sv ====
// GPIO input qualifier top: AXI4-Lite registers, pin synchronizers,
// per-group sample dividers and per-pin filters.
// Assumes pins are asynchronous and all logic runs on aclk.

`timescale 1ns/10ps
`default_nettype none

module gpq_qualifier
  import gpq_pkg::*;
#(
  parameter int NUM_PINS = 32,
  parameter int ADDR_W   = 8
)(
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Pins
  input  wire logic [NUM_PINS-1:0] pin_in,
  // Core and peripheral side
  output logic [NUM_PINS-1:0]      gpio_level,
  output logic [NUM_PINS-1:0]      periph_level
);

  localparam int NUM_GROUPS = NUM_PINS / GPQ_GROUP_PINS;

  // ==========================================================
  // Parameter check
  if ((NUM_PINS % GPQ_GROUP_PINS) != 0 || NUM_PINS < GPQ_GROUP_PINS
      || NUM_PINS > 32 || ADDR_W < 5) begin : g_bad_param
    $error("gpq_qualifier: NUM_PINS must be 8, 16, 24 or 32, ADDR_W >= 5");
  end

  // ==========================================================
  // Declarations
  logic [ADDR_W-1:0]   awaddr_q;
  logic                aw_got_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                w_got_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [1:0]          rresp_q;
  logic [31:0]         rdata_q;
  logic                do_wr;
  logic                do_rd;
  logic [7:0]          wr_ofs;
  logic [7:0]          rd_ofs;
  logic                wr_hit;
  logic [31:0]         rd_val;
  logic                rd_hit;

  // Software-visible configuration
  logic [31:0]         period_q;
  logic [31:0]         qsel_lo_q;
  logic [31:0]         qsel_hi_q;
  logic [31:0]         func_q;

  // Effective configuration, one stage behind the registers
  logic [31:0]         period_e_q;
  logic [63:0]         qsel_e_q;
  logic [31:0]         func_e_q;

  // Pin path
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] qual;
  logic [NUM_GROUPS-1:0] tick;
  logic [31:0]         level_rd;

  // ==========================================================
  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign do_wr         = aw_got_q && w_got_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_wr) begin
      w_got_q <= 1'b0;
    end
  end

  assign wr_ofs = {{(8-5){1'b0}}, awaddr_q[4:2], 2'b00};
  assign wr_hit = (awaddr_q[ADDR_W-1:5] == '0)
               && (wr_ofs <= GPQ_LEVEL_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= GPQ_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? GPQ_RESP_OKAY : GPQ_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Configuration registers, one process per register
  // Level register is read-only; writes to it are accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q <= GPQ_PERIOD_RST;
    end else if (do_wr && wr_hit && (wr_ofs == GPQ_PERIOD_OFS)) begin
      period_q <= gpq_strb(period_q, wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qsel_lo_q <= GPQ_QSEL_RST;
    end else if (do_wr && wr_hit && (wr_ofs == GPQ_QSEL_LO_OFS)) begin
      qsel_lo_q <= gpq_strb(qsel_lo_q, wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qsel_hi_q <= GPQ_QSEL_RST;
    end else if (do_wr && wr_hit && (wr_ofs == GPQ_QSEL_HI_OFS)) begin
      qsel_hi_q <= gpq_strb(qsel_hi_q, wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_q <= GPQ_FUNC_RST;
    end else if (do_wr && wr_hit && (wr_ofs == GPQ_FUNC_OFS)) begin
      func_q <= gpq_strb(func_q, wdata_q, wstrb_q);
    end
  end

  // ==========================================================
  // Effective configuration
  // Extra stage so a write acts on the second edge after it lands;
  // filters and dividers never see a half-updated register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_e_q <= GPQ_PERIOD_RST;
    end else begin
      period_e_q <= period_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qsel_e_q <= {GPQ_QSEL_RST, GPQ_QSEL_RST};
    end else begin
      qsel_e_q <= {qsel_hi_q, qsel_lo_q};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_e_q <= GPQ_FUNC_RST;
    end else begin
      func_e_q <= func_q;
    end
  end

  // ==========================================================
  // Read channel
  assign s_axi_arready = !rvalid_q;
  assign do_rd         = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign rd_ofs = {{(8-5){1'b0}}, s_axi_araddr[4:2], 2'b00};

  always_comb begin
    rd_val = '0;
    rd_hit = (s_axi_araddr[ADDR_W-1:5] == '0);
    unique case (rd_ofs)
      GPQ_PERIOD_OFS:  rd_val = period_q;
      GPQ_QSEL_LO_OFS: rd_val = qsel_lo_q;
      GPQ_QSEL_HI_OFS: rd_val = qsel_hi_q;
      GPQ_FUNC_OFS:    rd_val = func_q;
      GPQ_LEVEL_OFS:   rd_val = level_rd;
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= GPQ_RESP_OKAY;
    end else if (do_rd) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_hit ? rd_val : 32'h0000_0000;
      rresp_q  <= rd_hit ? GPQ_RESP_OKAY : GPQ_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Unused fields of a narrow port read as zero
  assign level_rd = {{(32-NUM_PINS){1'b0}}, qual};

  // ==========================================================
  // Pin synchronizers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // One sample divider per eight pins
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
    gpq_sample_tick u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .period  (period_e_q[GPQ_PERIOD_W*g +: GPQ_PERIOD_W]),
      .tick    (tick[g])
    );
  end

  // ==========================================================
  // Per-pin mode decode and filter
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    gpq_mode_t sel;
    gpq_mode_t mode;

    assign sel = gpq_mode_t'(qsel_e_q[GPQ_QSEL_W*p +: GPQ_QSEL_W]);

    // GPIO use cannot run unclocked, so it degrades to sync only
    assign mode = (sel == GPQ_ASYNC && !func_e_q[p]) ? GPQ_SYNC : sel;

    gpq_pin_filter u_filt (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .level_in  (sync2_q[p]),
      .tick      (tick[p / GPQ_GROUP_PINS]),
      .mode      (mode),
      .level_out (qual[p])
    );

    // Raw path keeps trip inputs alive without a running clock
    assign periph_level[p] = (sel == GPQ_ASYNC && func_e_q[p])
                           ? pin_in[p] : qual[p];
  end

  // Data register and GPIO both see the qualified level
  assign gpio_level = qual;

endmodule

`default_nettype wire

// ==== rtl/gpq_sample_tick.sv ====
// Sampling-period divider for one group of eight pins.
// Assumes period arrives from the effective configuration stage.

`timescale 1ns/10ps
`default_nettype none

module gpq_sample_tick
  import gpq_pkg::*;
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Configuration
  input  wire logic [GPQ_PERIOD_W-1:0] period,
  // Sample enable
  output logic                         tick
);

  logic [GPQ_CNT_W-1:0] cnt_q;
  logic [GPQ_CNT_W-1:0] lim_m1;

  // ==========================================================
  // Divider
  assign lim_m1 = {period, 1'b0} - {{(GPQ_CNT_W-1){1'b0}}, 1'b1};

  // Greater-or-equal so a shortened period restarts at once
  assign tick = (period == '0) || (cnt_q >= lim_m1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + {{(GPQ_CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// ==== test/gpq_pin_source.sv ====
// Pin-side source model: the asynchronous signals on the pins.
// Assumes the bench asks for levels just after aclk edges.
`timescale 1ns/10ps
`default_nettype none
module gpq_pin_source #(
  parameter int NUM_PINS = 32
)(
  // Request from the bench
  input  wire logic [NUM_PINS-1:0] want,
  // Pins
  output logic [NUM_PINS-1:0]      pin_in
);
  // ==========================================
  // Levels land well away from the clock edge and are held exactly as long as asked
  initial pin_in = '0;
  always @(want) begin
    pin_in <= #3.3 want;
  end
endmodule
`default_nettype wire

// ==== test/gpq_qualifier_monitor.sv ====
// Checker for bus handshakes and pin-to-level relations.
// Assumes binding to gpq_qualifier; reset is held two cycles or more.
`timescale 1ns/10ps
`default_nettype none
module gpq_qualifier_monitor
  import gpq_pkg::*;
#(
  parameter int NUM_PINS = 32,
  parameter int ADDR_W   = 8
)(
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Bus
  input wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input wire logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic [1:0]          s_axi_bresp, s_axi_rresp,
  input wire logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid, s_axi_rready,
  // Pins and levels
  input wire logic [NUM_PINS-1:0] pin_in, gpio_level, periph_level
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Pin path: two sync flops plus the filter flop
  a_pin_to_level: assert property (
    ((gpio_level ^ $past(gpio_level)) & (gpio_level ^ $past(pin_in, 3))) == '0)
    else $error("qualified level moved away from the pin");
  a_periph_source: assert property (
    ((periph_level ^ gpio_level) & (periph_level ^ pin_in)) == '0)
    else $error("peripheral level neither qualified nor raw");
  // ==========================================
  // Register bus
  // Both channels land in holding flops first, so the answer trails by two edges
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write response");
  a_unmapped_decerr: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && (s_axi_awaddr >> 2) > (ADDR_W'(GPQ_LEVEL_OFS) >> 2) |-> ##2 s_axi_bresp == GPQ_RESP_DECERR)
    else $error("unmapped write not refused");
  a_bvalid_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_rvalid_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed early");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule
bind gpq_qualifier gpq_qualifier_monitor #(.NUM_PINS(NUM_PINS), .ADDR_W(ADDR_W)) u_gpq_qualifier_monitor (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_in(pin_in), .gpio_level(gpio_level), .periph_level(periph_level));
`default_nettype wire

// ==== test/gpq_qualifier_tb_top.sv ====
// Bench for the GPIO input qualifier: reset values, bus corners, raw path
// and random pulses against a randomly chosen pin's sampling window.
// Assumes the pin source model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module gpq_qualifier_tb_top;
  import gpq_pkg::*;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, want, pins, glev, plev;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          fail_count, checks_done;

  gpq_qualifier u_gpq_qualifier (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pins), .gpio_level(glev), .periph_level(plev));
  gpq_pin_source u_gpq_pin_source (.want(want), .pin_in(pins));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge aclk);
    fail_count++;
    finish_test();
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", 32'(er), 32'(rresp));
    chk("rdata", ed, rdata);
  endtask

  function automatic int per(input int n);
    return (n == 0) ? 1 : 2 * n;
  endfunction

  function automatic int samples(input logic [1:0] c);
    return (c == 2'b01) ? 3 : (c == 2'b10) ? 6 : 1;
  endfunction

  // Accepted pulses get one extra period plus a cycle, since phase is unknown
  task automatic trial(input int p, input int n, input int s, input bit acc);
    int   len;
    logic seen;
    len = acc ? per(n) * s + 1 : per(n) * (s - 1);
    seen = 1'b0;
    for (int i = 0; i < len + per(n) * (s + 1) + 8; i++) begin
      want[p] <= (i < len);
      @(posedge aclk);
      seen = seen | glev[p];
    end
    chk("pulse seen", 32'(acc), 32'(seen));
    chk("back low", 32'h0, 32'(glev[p]));
  endtask

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] pv, ql, qh;
    logic [63:0] qq;
    int          p, s;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, want} = '0;
    void'($urandom(69038));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(GPQ_QSEL_LO_OFS, GPQ_QSEL_RST, GPQ_RESP_OKAY);
    rd(GPQ_QSEL_HI_OFS, GPQ_QSEL_RST, GPQ_RESP_OKAY);
    rd(GPQ_PERIOD_OFS, GPQ_PERIOD_RST, GPQ_RESP_OKAY);
    rd(GPQ_FUNC_OFS, GPQ_FUNC_RST, GPQ_RESP_OKAY);
    trial(5, 0, 1, 1);
    wr(8'h14, 32'hffff_ffff, 4'hf, GPQ_RESP_DECERR);
    rd(8'h14, 32'h0, GPQ_RESP_DECERR);
    wr(GPQ_LEVEL_OFS, 32'hffff_ffff, 4'hf, GPQ_RESP_OKAY);
    rd(GPQ_LEVEL_OFS, 32'h0, GPQ_RESP_OKAY);
    wr(GPQ_PERIOD_OFS, 32'hffff_ffff, 4'h2, GPQ_RESP_OKAY);
    rd(GPQ_PERIOD_OFS, 32'h0000_ff00, GPQ_RESP_OKAY);
    wr(GPQ_PERIOD_OFS, 32'h0000_0400, 4'hf, GPQ_RESP_OKAY);
    wr(GPQ_QSEL_LO_OFS, 32'haaaa_aaaa, 4'hf, GPQ_RESP_OKAY);
    trial(3, 0, 6, 1);
    trial(12, 4, 6, 0);
    // Raw path only for peripheral function in unsynchronized mode
    wr(GPQ_QSEL_LO_OFS, 32'hffff_ffff, 4'hf, GPQ_RESP_OKAY);
    wr(GPQ_QSEL_HI_OFS, 32'hffff_ffff, 4'hf, GPQ_RESP_OKAY);
    wr(GPQ_FUNC_OFS, 32'hffff_ffff, 4'hf, GPQ_RESP_OKAY);
    repeat (2) @(posedge aclk);
    want <= 32'ha5c3_0f96;
    #5;
    chk("raw periph", 32'ha5c3_0f96, plev);
    chk("gpio not raw", 32'h0, glev);
    repeat (4) @(posedge aclk);
    chk("gpio sync", 32'ha5c3_0f96, glev);
    rd(GPQ_LEVEL_OFS, 32'ha5c3_0f96, GPQ_RESP_OKAY);
    wr(GPQ_FUNC_OFS, 32'h0, 4'hf, GPQ_RESP_OKAY);
    repeat (2) @(posedge aclk);
    want <= 32'h5a3c_f069;
    #5;
    chk("gpio periph", 32'ha5c3_0f96, plev);
    @(posedge aclk);
    want <= '0;
    repeat (8) @(posedge aclk);
    for (int t = 0; t < 24; t++) begin
      pv = $urandom() & 32'h0303_0303;
      ql = $urandom();
      qh = $urandom();
      p = $urandom_range(31);
      wr(GPQ_PERIOD_OFS, pv, 4'hf, GPQ_RESP_OKAY);
      wr(GPQ_QSEL_LO_OFS, ql, 4'hf, GPQ_RESP_OKAY);
      wr(GPQ_QSEL_HI_OFS, qh, 4'hf, GPQ_RESP_OKAY);
      rd(GPQ_PERIOD_OFS, pv, GPQ_RESP_OKAY);
      qq = {qh, ql};
      s = samples(qq[2*p +: 2]);
      trial(p, int'(pv[8*(p/8) +: 8]), s, (s == 1) || ($urandom_range(1) == 1));
    end
    finish_test();
  end
endmodule
`default_nettype wire
